// >>> accel_threshold_interrupt_generator.sv
// Register file, two event generators and pin routing of the accelerometer
// What this block does
// R1 - Y sample as low and high byte
// R2 - Z sample as low and high byte
// R3 - Config 30h: combine, six-direction, six enables
// R4 - High enable requests above threshold
// R5 - Low enable requests below threshold
// R6 - Combine bit selects OR or AND
// R7 - Six-direction gives movement or position
// R8 - Config registers reset to zero
// R9 - Source 31h read-only, bit7 zero
// R10 - Active flag shows generated interrupt
// R11 - Source read clears active and pin
// R12 - Event flags show occurred events
// R13 - Threshold 32h holds seven bits
// R14 - Duration 33h holds seven bits
// R15 - Duration resets to zero, immediate events
// R16 - Second config 34h, same layout
// R17 - Latch bit holds source until read
// R18 - Routing field selects each pin source
// R19 - Request waits programmed duration of samples
// R20 - Movement on change, position while held
// R21 - Host programs limits first, reads source
`timescale 1ns/1ns
`default_nettype none
module accel_threshold_interrupt_generator (
    input  wire logic                            clk_sys,
    input  wire logic                            rst,
    input  wire logic                            sampleTick,
    input  wire logic [accel_int_pkg::SAMPLE_W-1:0] accelX,
    input  wire logic [accel_int_pkg::SAMPLE_W-1:0] accelY,
    input  wire logic [accel_int_pkg::SAMPLE_W-1:0] accelZ,
    input  wire logic [7:0]                      regAddr,
    input  wire logic                            regWrEn,
    input  wire logic [7:0]                      regWrData,
    input  wire logic                            regRdEn,
    output logic [7:0]                           regRdData,
    output logic                                 regRdValid,
    input  wire logic                            gen1LatchRequest,
    input  wire logic                            gen2LatchRequest,
    input  wire logic [1:0]                      pin1RoutingSelect,
    input  wire logic [1:0]                      pin2RoutingSelect,
    input  wire logic [6:0]                      gen2Threshold,
    input  wire logic [6:0]                      gen2Duration,
    input  wire logic                            gen2SourceRead,
    input  wire logic                            dataReady,
    input  wire logic                            bootRunning,
    output logic [7:0]                           gen2Source,
    output logic                                 int1Pin,
    output logic                                 int2Pin
);
    import accel_int_pkg::*;

    typedef struct packed {
        event_config_t       cfg1;
        event_config_t       cfg2;
        logic [6:0]          ths1;
        logic [6:0]          dur1;
        logic [SAMPLE_W-1:0] sampleY;
        logic [SAMPLE_W-1:0] sampleZ;
        logic [7:0]          rdData;
        logic                rdValid;
        logic                int1;
        logic                int2;
        event_source_t       gen2Src;
    } top_state_t;

    // R8 reset values
    localparam top_state_t RESET_STATE = '{
        cfg1:    event_config_t'(CFG_RESET),
        cfg2:    event_config_t'(CFG_RESET),
        ths1:    THS_RESET,
        // R15 duration reset
        dur1:    DUR_RESET,
        sampleY: '0,
        sampleZ: '0,
        rdData:  UNMAPPED_READ,
        rdValid: 1'b0,
        int1:    1'b0,
        int2:    1'b0,
        gen2Src: event_source_t'(SRC_RESET)
    };

    top_state_t    q;
    top_state_t    d;
    event_source_t src1;
    event_source_t src2;
    logic          gen1Read;
    logic          gen1Irq;
    logic          gen2Irq;

    // One carrier per generator
    gen_if g1 ();
    gen_if g2 ();

    // Only this read acknowledges the first source
    assign gen1Read = regRdEn && (regAddr == ADDR_GEN1_SRC);

    assign g1.accelX         = accelX;
    assign g1.accelY         = accelY;
    assign g1.accelZ         = accelZ;
    assign g1.sampleTick     = sampleTick;
    assign g1.eventConfig    = q.cfg1;
    assign g1.thresholdValue = q.ths1;
    assign g1.durationValue  = q.dur1;
    assign g1.latchRequest   = gen1LatchRequest;
    assign g1.sourceRead     = gen1Read;
    assign src1              = g1.eventSource;

    // R16 second generator
    assign g2.accelX         = accelX;
    assign g2.accelY         = accelY;
    assign g2.accelZ         = accelZ;
    assign g2.sampleTick     = sampleTick;
    assign g2.eventConfig    = q.cfg2;
    assign g2.thresholdValue = gen2Threshold;
    assign g2.durationValue  = gen2Duration;
    assign g2.latchRequest   = gen2LatchRequest;
    assign g2.sourceRead     = gen2SourceRead;
    assign src2              = g2.eventSource;

    event_generator u_gen1 (
        .clk_sys (clk_sys),
        .rst     (rst),
        .bus     (g1.gen)
    );

    event_generator u_gen2 (
        .clk_sys (clk_sys),
        .rst     (rst),
        .bus     (g2.gen)
    );

    // Pins routed to their own generator track its active flag, so a clearing read drops them
    assign gen1Irq = src1.generatorActiveFlag;
    assign gen2Irq = src2.generatorActiveFlag;

    always_comb begin
        d = q;
        // Valid echoes the strobe for one cycle
        d.rdValid = regRdEn;
        // Exported copy lags the generator by one cycle
        d.gen2Src = src2;
        // Readout copies move only with a new sample
        if (sampleTick) begin
            d.sampleY = accelY;
            d.sampleZ = accelZ;
        end

        // Read-only and unmapped addresses ignore writes
        if (regWrEn) begin
            if (regAddr == ADDR_GEN1_CFG) begin
                // R3 first config write
                d.cfg1 = event_config_t'(regWrData);
            end else if (regAddr == ADDR_GEN1_THS) begin
                // R13 seven bit threshold
                d.ths1 = regWrData[6:0];
            end else if (regAddr == ADDR_GEN1_DUR) begin
                // R14 seven bit duration
                d.dur1 = regWrData[6:0];
            end else if (regAddr == ADDR_GEN2_CFG) begin
                // R16 second config write
                d.cfg2 = event_config_t'(regWrData);
            end
        end

        // Held between reads so a slow host sees a stable byte
        if (regRdEn) begin
            if (regAddr == ADDR_Y_LOW) begin
                // R1 Y low byte
                d.rdData = q.sampleY[7:0];
            end else if (regAddr == ADDR_Y_HIGH) begin
                d.rdData = q.sampleY[15:8];
            end else if (regAddr == ADDR_Z_LOW) begin
                // R2 Z byte pair
                d.rdData = q.sampleZ[7:0];
            end else if (regAddr == ADDR_Z_HIGH) begin
                d.rdData = q.sampleZ[15:8];
            end else if (regAddr == ADDR_GEN1_CFG) begin
                d.rdData = q.cfg1;
            end else if (regAddr == ADDR_GEN1_SRC) begin
                // R9 source readback
                d.rdData = {1'b0, src1.generatorActiveFlag,
                            src1.eventFlags};
            end else if (regAddr == ADDR_GEN1_THS) begin
                d.rdData = {1'b0, q.ths1};
            end else if (regAddr == ADDR_GEN1_DUR) begin
                d.rdData = {1'b0, q.dur1};
            end else if (regAddr == ADDR_GEN2_CFG) begin
                d.rdData = q.cfg2;
            end else begin
                d.rdData = UNMAPPED_READ;
            end
        end

        // R18 pin one routing
        case (pin1RoutingSelect)
            ROUTE_OWN:        d.int1 = gen1Irq;
            ROUTE_EITHER:     d.int1 = gen1Irq || gen2Irq;
            ROUTE_DATA_READY: d.int1 = dataReady;
            default:          d.int1 = bootRunning;
        endcase
        // Pin two uses the same decode
        case (pin2RoutingSelect)
            ROUTE_OWN:        d.int2 = gen2Irq;
            ROUTE_EITHER:     d.int2 = gen1Irq || gen2Irq;
            ROUTE_DATA_READY: d.int2 = dataReady;
            default:          d.int2 = bootRunning;
        endcase
    end

    // Synchronous reset keeps the reset a plain data input
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q <= RESET_STATE;
        end else begin
            q <= d;
        end
    end

    // Outputs come straight from the state flops
    assign regRdData  = q.rdData;
    assign regRdValid = q.rdValid;
    assign gen2Source = q.gen2Src;
    assign int1Pin    = q.int1;
    assign int2Pin    = q.int2;

    // Checks below, except cfgReset_a, are idle while reset is held
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence cfgWrite(logic [7:0] a);
        regWrEn && regAddr == a;
    endsequence

    sequence regRead(logic [7:0] a);
        regRdEn && regAddr == a;
    endsequence

    cfgReset_a: assert property ( // R8
        disable iff (1'b0)
        rst |=> q.cfg1 == CFG_RESET && q.cfg2 == CFG_RESET)
        else $error("config not zero after reset");

    cfgWrite_a: assert property ( // R3
        cfgWrite(ADDR_GEN1_CFG) |=> q.cfg1 == $past(regWrData))
        else $error("first config write lost");

    cfgRead_a: assert property ( // R3
        regRead(ADDR_GEN1_CFG) |=> regRdData == $past(q.cfg1))
        else $error("first config readback wrong");

    gen2Cfg_a: assert property ( // R16
        cfgWrite(ADDR_GEN2_CFG) ##1 !regWrEn ##1 regRead(ADDR_GEN2_CFG)
        |=> regRdData == $past(regWrData, 3))
        else $error("second config readback wrong");

    srcRead_a: assert property ( // R9
        regRead(ADDR_GEN1_SRC) |=> regRdValid && regRdData[7] == 1'b0
        && regRdData[6] == $past(gen1Irq))
        else $error("source readback wrong");

    thsWrite_a: assert property ( // R13
        cfgWrite(ADDR_GEN1_THS) |=> q.ths1 == $past(regWrData[6:0]))
        else $error("threshold write lost");

    thsRead_a: assert property ( // R13
        regRead(ADDR_GEN1_THS) |=> regRdData == {1'b0, $past(q.ths1)})
        else $error("threshold readback wrong");

    durWrite_a: assert property ( // R14
        cfgWrite(ADDR_GEN1_DUR) |=> q.dur1 == $past(regWrData[6:0]))
        else $error("duration write lost");

    yLowRead_a: assert property ( // R1
        regRead(ADDR_Y_LOW) |=> regRdData == $past(q.sampleY[7:0]))
        else $error("Y low byte readback wrong");

    zHighRead_a: assert property ( // R2
        regRead(ADDR_Z_HIGH) |=> regRdData == $past(q.sampleZ[15:8]))
        else $error("Z high byte readback wrong");

    pinOwn_a: assert property ( // R18
        pin1RoutingSelect == ROUTE_OWN |=> int1Pin == $past(gen1Irq))
        else $error("pin one not following own generator");

    pinEither_a: assert property ( // R18
        pin2RoutingSelect == ROUTE_EITHER
        |=> int2Pin == $past(gen1Irq || gen2Irq))
        else $error("pin two not following either generator");

    pinClear_a: assert property ( // R11
        gen1Read && !sampleTick && pin1RoutingSelect == ROUTE_OWN
        ##1 pin1RoutingSelect == ROUTE_OWN |=> !int1Pin)
        else $error("pin one not cleared by source read");

    gen2Copy_a: assert property ( // R16
        1'b1 |=> gen2Source == $past(src2))
        else $error("second source copy wrong");

    gen2Clear_a: assert property ( // R11
        gen2SourceRead && !sampleTick |=> ##1 !gen2Source[6])
        else $error("second source read did not clear active");
endmodule
`default_nettype wire

// >>> accel_int_pkg.sv
// Shared constants and types of the inertial interrupt generator block
`default_nettype none
package accel_int_pkg;
    localparam int         SAMPLE_W      = 16;
    localparam logic [7:0] ADDR_Y_LOW    = 8'h2a;
    localparam logic [7:0] ADDR_Y_HIGH   = 8'h2b;
    localparam logic [7:0] ADDR_Z_LOW    = 8'h2c;
    localparam logic [7:0] ADDR_Z_HIGH   = 8'h2d;
    localparam logic [7:0] ADDR_GEN1_CFG = 8'h30;
    localparam logic [7:0] ADDR_GEN1_SRC = 8'h31;
    localparam logic [7:0] ADDR_GEN1_THS = 8'h32;
    localparam logic [7:0] ADDR_GEN1_DUR = 8'h33;
    localparam logic [7:0] ADDR_GEN2_CFG = 8'h34;
    localparam logic [7:0] CFG_RESET     = 8'h00;
    localparam logic [7:0] SRC_RESET     = 8'h00;
    localparam logic [6:0] THS_RESET     = 7'h00;
    localparam logic [6:0] DUR_RESET     = 7'h00;
    localparam logic [6:0] COUNT_MAX     = 7'h7f;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam logic [1:0] ROUTE_OWN        = 2'h0;
    localparam logic [1:0] ROUTE_EITHER     = 2'h1;
    localparam logic [1:0] ROUTE_DATA_READY = 2'h2;
    localparam logic [1:0] ROUTE_BOOT       = 2'h3;

    // Event bits 5..0: Z high, Z low, Y high, Y low, X high, X low
    typedef struct packed {
        logic       combineModeSelect;
        logic       sixDirectionEnable;
        logic [5:0] eventEnable;
    } event_config_t;

    typedef struct packed {
        logic       fixedZero;
        logic       generatorActiveFlag;
        logic [5:0] eventFlags;
    } event_source_t;
endpackage
`default_nettype wire

// >>> gen_if.sv
// Connection from the register file to one event generator
`timescale 1ns/1ns
`default_nettype none
interface gen_if;
    import accel_int_pkg::*;
    logic [SAMPLE_W-1:0] accelX;
    logic [SAMPLE_W-1:0] accelY;
    logic [SAMPLE_W-1:0] accelZ;
    logic                sampleTick;
    event_config_t       eventConfig;
    logic [6:0]          thresholdValue;
    logic [6:0]          durationValue;
    logic                latchRequest;
    logic                sourceRead;
    event_source_t       eventSource;

    modport ctrl (
        output accelX, accelY, accelZ, sampleTick, eventConfig,
        output thresholdValue, durationValue, latchRequest, sourceRead,
        input  eventSource
    );
    modport gen (
        input  accelX, accelY, accelZ, sampleTick, eventConfig,
        input  thresholdValue, durationValue, latchRequest, sourceRead,
        output eventSource
    );
endinterface
`default_nettype wire

// >>> event_generator.sv
// One inertial event generator: compare, combine, persist and source flags
`timescale 1ns/1ns
`default_nettype none
module event_generator (
    input  wire logic clk_sys,
    input  wire logic rst,
    gen_if.gen        bus
);
    import accel_int_pkg::*;

    typedef struct packed {
        logic [5:0]    prevDir;
        logic [6:0]    persistCount;
        logic          held;
        event_source_t src;
    } gen_state_t;

    gen_state_t      q;
    gen_state_t      d;
    logic [2:0][7:0] axisTop;
    logic [5:0]      threshVec;
    logic [5:0]      dirVec;
    logic [5:0]      evVec;
    logic [5:0]      en;
    logic            cond;
    logic            req;

    // Only the top byte meets the 7-bit threshold
    assign axisTop = {bus.accelZ[SAMPLE_W-1 -: 8],
                      bus.accelY[SAMPLE_W-1 -: 8],
                      bus.accelX[SAMPLE_W-1 -: 8]};
    assign en = bus.eventConfig.eventEnable;

    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : g_axis
            logic [7:0] mag;
            assign mag = axisTop[i][7] ? (8'h00 - axisTop[i]) : axisTop[i];
            // R4 high compare
            assign threshVec[2*i+1] = mag > {1'b0, bus.thresholdValue};
            // R5 low compare
            assign threshVec[2*i] = mag < {1'b0, bus.thresholdValue};
            // Sign picks the direction once beyond threshold
            assign dirVec[2*i+1] = !axisTop[i][7] && threshVec[2*i+1];
            assign dirVec[2*i] = axisTop[i][7] && threshVec[2*i+1];
        end
    endgenerate

    always_comb begin
        d = q;
        evVec = 6'h00;
        cond = 1'b0;
        req = 1'b0;
        if (bus.eventConfig.sixDirectionEnable) begin
            evVec = dirVec & en;
            // R7 position or movement
            if (bus.eventConfig.combineModeSelect) begin
                cond = evVec != 6'h00;
            end else begin
                // R20 new direction only
                cond = (evVec != 6'h00) && (evVec != q.prevDir);
            end
        end else begin
            evVec = threshVec & en;
            // R6 and or combine
            if (bus.eventConfig.combineModeSelect) begin
                cond = (en != 6'h00) && ((threshVec & en) == en);
            end else begin
                cond = |evVec;
            end
        end
        // R11 read clears active
        if (bus.sourceRead) begin
            d.src.generatorActiveFlag = 1'b0;
            d.held = 1'b0;
        end
        // Sample update comes after the clear so a new event wins
        if (bus.sampleTick) begin
            d.prevDir = evVec;
            if (cond) begin
                // R19 persist duration count
                req = q.persistCount >= bus.durationValue;
                if (q.persistCount != COUNT_MAX) begin
                    d.persistCount = q.persistCount + 7'h01;
                end
            end else begin
                d.persistCount = 7'h00;
            end
            // R17 latched or live
            if (!bus.latchRequest) begin
                d.src.eventFlags = evVec;
                d.src.generatorActiveFlag = req;
                d.held = 1'b0;
            end else if (req && !d.held) begin
                // R12 capture event flags
                d.src.eventFlags = evVec;
                // R10 active flag set
                d.src.generatorActiveFlag = 1'b1;
                d.held = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign bus.eventSource = q.src;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence qualifiedSample;
        bus.sampleTick && req;
    endsequence
    sequence readAlone;
        bus.sourceRead && !bus.sampleTick;
    endsequence

    activeSet_a: assert property ( // R10
        qualifiedSample |=> q.src.generatorActiveFlag)
        else $error("active flag not set on request");
    readClear_a: assert property ( // R11
        readAlone |=> !q.src.generatorActiveFlag)
        else $error("source read did not clear active");
    liveFlags_a: assert property ( // R12
        bus.sampleTick && !bus.latchRequest
        |=> q.src.eventFlags == $past(evVec))
        else $error("live flags do not follow events");
    latchHold_a: assert property ( // R17
        q.held && !bus.sourceRead
        |=> q.held && $stable(q.src.eventFlags))
        else $error("latched source changed before read");
    zeroDuration_a: assert property ( // R15
        bus.sampleTick && cond && bus.durationValue == 7'h00
        && !bus.latchRequest |=> q.src.generatorActiveFlag)
        else $error("zero duration did not assert at once");
    andMiss_a: assert property ( // R6
        bus.sampleTick && !bus.latchRequest
        && !bus.eventConfig.sixDirectionEnable
        && bus.eventConfig.combineModeSelect
        && ((threshVec & en) != en) |=> !q.src.generatorActiveFlag)
        else $error("AND mode fired with an enabled event missing");
endmodule
`default_nettype wire

// >>> reg_host_model.sv
// Host-side master of the register strobe port
`timescale 1ns/1ns
`default_nettype none
module reg_host_model (
    input  wire logic       clk_sys,
    input  wire logic [7:0] regRdData,
    input  wire logic       regRdValid,
    output logic [7:0]      regAddr,
    output logic            regWrEn,
    output logic [7:0]      regWrData,
    output logic            regRdEn
);
    initial begin
        regAddr = 8'h00;
        regWrEn = 1'b0;
        regWrData = 8'h00;
        regRdEn = 1'b0;
    end

    // Idle address and data flip so a stale value is never mistaken for live
    task automatic releaseBus();
        @(negedge clk_sys);
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = ~regAddr;
        regWrData = ~regWrData;
    endtask

    task automatic writeReg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_sys);
        regAddr = addr;
        regWrData = data;
        regWrEn = 1'b1;
        releaseBus();
    endtask

    // Answer is due exactly one cycle after the strobe, so only one edge waits
    task automatic readReg(input logic [7:0] addr, output logic [7:0] data,
                           output logic ok);
        @(negedge clk_sys);
        regAddr = addr;
        regRdEn = 1'b1;
        releaseBus();
        ok = (regRdValid === 1'b1);
        data = regRdData;
    endtask
endmodule
`default_nettype wire

// >>> accel_threshold_interrupt_generator_tb_top.sv
// Self-checking bench of the inertial interrupt generator block
`timescale 1ns/1ns
`default_nettype none
module accel_threshold_interrupt_generator_tb_top;
    import accel_int_pkg::*;
    typedef struct packed {
        logic [7:0]  cfg;
        logic [15:0] accY;
        logic [15:0] accZ;
        logic        pin;
    } event_row_t;

    logic                clk_sys, rst, sampleTick, regWrEn, regRdEn;
    logic [SAMPLE_W-1:0] accelX, accelY, accelZ;
    logic [7:0]          regAddr, regWrData, regRdData, gen2Source;
    logic                regRdValid, gen1LatchRequest, gen2LatchRequest;
    logic [1:0]          pin1RoutingSelect, pin2RoutingSelect;
    logic [6:0]          gen2Threshold, gen2Duration;
    logic                gen2SourceRead, dataReady, bootRunning;
    logic                int1Pin, int2Pin;
    int                  miscompares, checkCount, i;
    event_row_t          rows [13];
    logic [7:0] wrAddr [6] = '{ADDR_GEN1_THS, ADDR_GEN1_DUR, ADDR_GEN1_SRC,
                               ADDR_GEN1_CFG, ADDR_GEN2_CFG, 8'h3f};
    logic [7:0] wrData [6] = '{8'hff, 8'h83, 8'hff, 8'ha5, 8'h5a, 8'h11};
    logic [7:0] rdExp [6]  = '{8'h7f, 8'h03, 8'h00, 8'ha5, 8'h5a, 8'h00};
    logic [7:0] smpExp [4] = '{8'h23, 8'h81, 8'h01, 8'h7f};

    accel_threshold_interrupt_generator DUT (
        .clk_sys(clk_sys), .rst(rst), .sampleTick(sampleTick),
        .accelX(accelX), .accelY(accelY), .accelZ(accelZ),
        .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
        .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
        .gen1LatchRequest(gen1LatchRequest),
        .gen2LatchRequest(gen2LatchRequest),
        .pin1RoutingSelect(pin1RoutingSelect),
        .pin2RoutingSelect(pin2RoutingSelect),
        .gen2Threshold(gen2Threshold), .gen2Duration(gen2Duration),
        .gen2SourceRead(gen2SourceRead), .dataReady(dataReady),
        .bootRunning(bootRunning), .gen2Source(gen2Source),
        .int1Pin(int1Pin), .int2Pin(int2Pin)
    );

    reg_host_model host (
        .clk_sys(clk_sys), .regRdData(regRdData), .regRdValid(regRdValid),
        .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
        .regRdEn(regRdEn)
    );

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic checkValue(input string what, input logic [7:0] seen,
                              input logic [7:0] expected);
        checkCount++;
        if (seen !== expected) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what,
                     expected, seen);
        end
    endtask

    task automatic completeRun();
        if (miscompares == 0 && checkCount > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic readCheck(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] data;
        logic       ok;
        host.readReg(addr, data, ok);
        checkValue($sformatf("read valid %h", addr), {7'h00, ok}, 8'h01);
        checkValue($sformatf("register %h", addr), data, exp);
    endtask

    // Samples are valid only with the tick; outside it they show a flip
    task automatic tick(input logic [15:0] y, input logic [15:0] z);
        @(negedge clk_sys);
        accelX = 16'h0000;
        accelY = y;
        accelZ = z;
        sampleTick = 1'b1;
        @(negedge clk_sys);
        sampleTick = 1'b0;
        accelX = 16'hffff;
        accelY = ~y;
        accelZ = ~z;
        repeat (2) @(negedge clk_sys);
    endtask

    task automatic pinCheck(input string what, input logic seen,
                            input logic exp);
        checkValue(what, {7'h00, seen}, {7'h00, exp});
    endtask

    initial begin
        rst = 1'b1;
        sampleTick = 1'b0;
        accelX = 16'h0000;
        accelY = 16'h0000;
        accelZ = 16'h0000;
        gen1LatchRequest = 1'b0;
        gen2LatchRequest = 1'b0;
        pin1RoutingSelect = ROUTE_OWN;
        pin2RoutingSelect = ROUTE_EITHER;
        gen2Threshold = 7'h10;
        gen2Duration = 7'h00;
        gen2SourceRead = 1'b0;
        dataReady = 1'b0;
        bootRunning = 1'b0;
        miscompares = 0;
        checkCount = 0;
        // Threshold 10h: top byte 20h and e0h are high, 05h is low
        rows = '{'{8'h20, 16'h0000, 16'h2000, 1'b1},
                 '{8'h00, 16'h0000, 16'h2000, 1'b0},
                 '{8'h10, 16'h0000, 16'h0500, 1'b1},
                 '{8'h10, 16'h0000, 16'h2000, 1'b0},
                 '{8'h28, 16'h0000, 16'h2000, 1'b1},
                 '{8'ha8, 16'h0000, 16'h2000, 1'b0},
                 '{8'ha8, 16'h2000, 16'h2000, 1'b1},
                 '{8'he0, 16'h0000, 16'h2000, 1'b1},
                 '{8'he0, 16'h0000, 16'h2000, 1'b1},
                 '{8'h70, 16'h0000, 16'h2000, 1'b0},
                 '{8'h70, 16'h0000, 16'he000, 1'b1},
                 '{8'h70, 16'h0000, 16'he000, 1'b0},
                 '{8'h30, 16'h0000, 16'h1000, 1'b0}};
        repeat (16) @(negedge clk_sys);
        rst = 1'b0;
        for (i = 0; i < 5; i++)
            readCheck(ADDR_GEN1_CFG + 8'(i), 8'h00);
        pinCheck("int1Pin", int1Pin, 1'b0);
        for (i = 0; i < 6; i++) begin
            host.writeReg(wrAddr[i], wrData[i]);
            readCheck(wrAddr[i], rdExp[i]);
        end
        tick(16'h8123, 16'h7f01);
        for (i = 0; i < 4; i++)
            readCheck(ADDR_Y_LOW + 8'(i), smpExp[i]);
        host.writeReg(ADDR_GEN2_CFG, 8'h00);
        host.writeReg(ADDR_GEN1_DUR, 8'h00);
        host.writeReg(ADDR_GEN1_THS, 8'h10);
        foreach (rows[i]) begin
            host.writeReg(ADDR_GEN1_CFG, rows[i].cfg);
            tick(rows[i].accY, rows[i].accZ);
            pinCheck("int1Pin", int1Pin, rows[i].pin);
            pinCheck("int2Pin", int2Pin, rows[i].pin);
        end
        host.writeReg(ADDR_GEN1_DUR, 8'h02);
        host.writeReg(ADDR_GEN1_CFG, 8'h20);
        for (i = 0; i < 3; i++) begin
            tick(16'h0000, 16'h2000);
            pinCheck("int1Pin", int1Pin, i == 2);
        end
        host.writeReg(ADDR_GEN1_DUR, 8'h00);
        host.writeReg(ADDR_GEN1_CFG, 8'h30);
        tick(16'h0000, 16'h1000);
        gen1LatchRequest = 1'b1;
        tick(16'h0000, 16'h2000);
        pinCheck("int1Pin", int1Pin, 1'b1);
        tick(16'h0000, 16'h0500);
        readCheck(ADDR_GEN1_SRC, 8'h60);
        @(negedge clk_sys);
        pinCheck("int1Pin", int1Pin, 1'b0);
        readCheck(ADDR_GEN1_SRC, 8'h20);
        tick(16'h0000, 16'h0500);
        readCheck(ADDR_GEN1_SRC, 8'h50);
        gen1LatchRequest = 1'b0;
        for (i = 2; i < 4; i++) begin
            pin1RoutingSelect = 2'(i);
            dataReady = 1'b1;
            bootRunning = 1'b0;
            repeat (2) @(negedge clk_sys);
            pinCheck("int1Pin", int1Pin, i == 2);
            dataReady = 1'b0;
            bootRunning = 1'b1;
            repeat (2) @(negedge clk_sys);
            pinCheck("int1Pin", int1Pin, i == 3);
        end
        pin1RoutingSelect = ROUTE_OWN;
        bootRunning = 1'b0;
        pin2RoutingSelect = ROUTE_OWN;
        gen2LatchRequest = 1'b1;
        host.writeReg(ADDR_GEN2_CFG, 8'h20);
        tick(16'h0000, 16'h2000);
        pinCheck("int2Pin", int2Pin, 1'b1);
        checkValue("gen2Source", gen2Source, 8'h60);
        tick(16'h0000, 16'h1000);
        checkValue("gen2Source", gen2Source, 8'h60);
        gen2SourceRead = 1'b1;
        @(negedge clk_sys);
        gen2SourceRead = 1'b0;
        repeat (2) @(negedge clk_sys);
        checkValue("gen2Source", gen2Source, 8'h20);
        pinCheck("int2Pin", int2Pin, 1'b0);
        // Second reset in mid-run must clear the configuration again
        host.writeReg(ADDR_GEN1_CFG, 8'ha5);
        rst = 1'b1;
        repeat (16) @(negedge clk_sys);
        rst = 1'b0;
        readCheck(ADDR_GEN1_CFG, CFG_RESET);
        pinCheck("int1Pin", int1Pin, 1'b0);
        completeRun();
    end
endmodule
`default_nettype wire
